/* include/supply_seq_pkg.sv */
// Constants for the isolated supply enable and fault latch sequencer.
// Assumes a single 200 MHz core clock; all times become cycle counts here.
package supply_seq_pkg;
  localparam int CLK_MHZ = 200;
  // Least turn-on low time that clears a latch, in us
  localparam int TOGGLE_LOW_US = 150;
  localparam int TOGGLE_LOW_CYC = TOGGLE_LOW_US * CLK_MHZ + 1;
  // Start-up deglitch of rail checks, in us
  localparam int DEGLITCH_US = 3000;
  localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
  // Soft-start length and bias time-out, in us (plain defaults)
  localparam int SOFT_START_US = 896;
  localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
  localparam int SS_TIMEOUT_US = 2000;
  localparam int SS_TIMEOUT_CYC = SS_TIMEOUT_US * CLK_MHZ;
  // Input filter length in cycles
  localparam int FILT_LEN = 4;
  localparam int NUM_IN = 10;
  // Bit positions of the filtered input vector
  localparam int IN_ON = 0;
  localparam int IN_UV = 1;
  localparam int IN_ANA_UV = 2;
  localparam int IN_OV = 3;
  localparam int IN_MAIN_LOW = 4;
  localparam int IN_AUX_LOW = 5;
  localparam int IN_MAIN_HIGH = 6;
  localparam int IN_AUX_HIGH = 7;
  localparam int IN_FAILSAFE = 8;
  localparam int IN_THERM = 9;
  localparam logic [NUM_IN-1:0] IN_RESET = 10'h004;
  typedef enum logic [2:0] {
    ST_DISABLE = 3'b000,
    ST_SOFT = 3'b001,
    ST_DEGLITCH = 3'b010,
    ST_RUN = 3'b011,
    ST_LOCKOUT = 3'b100,
    ST_LATCHED = 3'b101
  } seq_state_t;
endpackage : supply_seq_pkg

/* core/supply_seq.sv */
// Enable, supply-ok and protection sequencing of an isolated converter.
// Assumes comparator levels arrive as plain inputs synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module supply_seq #(
  parameter int TOGGLE_CYC = supply_seq_pkg::TOGGLE_LOW_CYC,
  parameter int DEGL_CYC = supply_seq_pkg::DEGLITCH_CYC,
  parameter int SOFT_CYC = supply_seq_pkg::SOFT_START_CYC,
  parameter int TMO_CYC = supply_seq_pkg::SS_TIMEOUT_CYC
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Host side
  input wire logic turn_on_request,
  output logic supply_ok_n_oe,
  // Input supply comparators
  input wire logic input_low_lockout,
  input wire logic input_analog_low,
  input wire logic input_high_lockout,
  // Rail and temperature comparators
  input wire logic main_rail_low,
  input wire logic aux_rail_low,
  input wire logic main_rail_high,
  input wire logic aux_rail_high,
  input wire logic main_rail_bias_ok,
  input wire logic main_rail_failsafe,
  input wire logic thermal_trip,
  // Converter control and status
  output logic switching_en,
  output logic soft_start_active,
  output logic fault_latched,
  output supply_seq_pkg::seq_state_t seq_state
);
  import supply_seq_pkg::*;

  // Refuse timings the counters and the filter cannot serve
  if (TOGGLE_CYC < 2 || DEGL_CYC < 1 || SOFT_CYC < 1 || TMO_CYC <= SOFT_CYC
      || FILT_LEN < 2) begin : g_bad_timing
    $error("supply_seq: bad timing parameters");
  end

  localparam int CW = 32;

  logic [NUM_IN-1:0] raw_in;
  logic [NUM_IN-1:0] sync_a;
  logic [NUM_IN-1:0] sync_b;
  logic [NUM_IN-1:0] filt;
  logic bias_a;
  logic bias_b;
  logic [CW-1:0] low_cnt;
  logic toggle_armed;
  logic [CW-1:0] tmr;
  seq_state_t state;
  seq_state_t next_state;
  logic fault_now;
  logic trip;
  logic lockout;
  logic clear_ok;

  assign raw_in = {thermal_trip, main_rail_failsafe, aux_rail_high, main_rail_high,
                   aux_rail_low, main_rail_low, input_high_lockout, input_analog_low,
                   input_low_lockout, turn_on_request};

  // sync then filter
  // Two flops ahead of a run filter so a one-cycle glitch never moves the latch
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_a <= IN_RESET;
      sync_b <= IN_RESET;
      bias_a <= 1'b0;
      bias_b <= 1'b0;
    end else if (clk_en) begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      bias_a <= main_rail_bias_ok;
      bias_b <= bias_a;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_filt
      logic [FILT_LEN-1:0] hist;
      // Output moves only after FILT_LEN equal samples
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          hist <= {FILT_LEN{IN_RESET[gi]}};
          filt[gi] <= IN_RESET[gi];
        end else if (clk_en) begin
          hist <= {hist[FILT_LEN-2:0], sync_b[gi]};
          if (&hist) begin
            filt[gi] <= 1'b1;
          end else if (~|hist) begin
            filt[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // overload shows only as rail low; no current limit here
  assign fault_now = filt[IN_MAIN_LOW] | filt[IN_AUX_LOW] | filt[IN_MAIN_HIGH]
                   | filt[IN_AUX_HIGH] | filt[IN_FAILSAFE] | filt[IN_THERM];
  assign lockout = filt[IN_UV] | filt[IN_OV];

  // Immediate trips: fail-safe and thermal act in every running state, high in soft-start and run only
  always_comb begin
    trip = 1'b0;
    case (state)
      ST_SOFT: trip = filt[IN_MAIN_HIGH] | filt[IN_AUX_HIGH] | filt[IN_FAILSAFE]
                    | filt[IN_THERM];
      ST_DEGLITCH: trip = filt[IN_FAILSAFE] | filt[IN_THERM];
      ST_RUN: trip = fault_now;
      default: trip = 1'b0;
    endcase
  end

  // low-time counter
  // Counter saturates so a long low period cannot wrap back under the limit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      low_cnt <= '0;
      toggle_armed <= 1'b0;
    end else if (clk_en) begin
      if (filt[IN_ON]) begin
        low_cnt <= '0;
      end else if (low_cnt < CW'(TOGGLE_CYC)) begin
        low_cnt <= low_cnt + 1'b1;
      end
      // Any high disarms, so only the rising edge can release, never a held level
      if (state != ST_LATCHED || filt[IN_ON]) begin
        toggle_armed <= 1'b0;
      end else if (low_cnt >= CW'(TOGGLE_CYC - 1)) begin
        toggle_armed <= 1'b1;
      end
    end
  end

  // thermal cleared first
  // Judged on the first high cycle only; a fault then wastes the toggle
  assign clear_ok = toggle_armed & filt[IN_ON] & ~fault_now;

  // Sequencer transitions
  always_comb begin
    next_state = state;
    case (state)
      ST_DISABLE: begin
        if (lockout) begin
          next_state = ST_LOCKOUT;
        end else if (filt[IN_ON]) begin
          next_state = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (trip || (tmr >= CW'(TMO_CYC - 1) && !bias_b)) begin
          next_state = ST_LATCHED;
        end else if (tmr >= CW'(SOFT_CYC - 1) && bias_b) begin
          next_state = (filt[IN_MAIN_LOW] | filt[IN_AUX_LOW]) ? ST_LATCHED : ST_DEGLITCH;
        end
      end
      ST_DEGLITCH: begin
        if (trip) begin
          next_state = ST_LATCHED;
        end else if (tmr >= CW'(DEGL_CYC - 1)) begin
          next_state = fault_now ? ST_LATCHED : ST_RUN;
        end
      end
      ST_RUN: begin
        if (trip) begin
          next_state = ST_LATCHED;
        end
      end
      ST_LOCKOUT: begin
        if (!lockout) begin
          next_state = filt[IN_ON] ? ST_SOFT : ST_DISABLE;
        end
      end
      ST_LATCHED: begin
        if (clear_ok && !lockout) begin
          next_state = ST_SOFT;
        end
      end
      default: next_state = ST_DISABLE;
    endcase
    if ((state == ST_SOFT || state == ST_DEGLITCH || state == ST_RUN) && !filt[IN_ON]) begin
      next_state = ST_DISABLE;
    end
    // Lockouts stop running states without touching the latch
    if (state != ST_LATCHED && state != ST_LOCKOUT && lockout) begin
      next_state = ST_LOCKOUT;
    end
    if (filt[IN_ANA_UV]) begin
      next_state = ST_LOCKOUT;
    end
  end

  // State and phase timer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ST_DISABLE;
      tmr <= '0;
    end else if (clk_en) begin
      state <= next_state;
      if (next_state != state) begin
        tmr <= '0;
      end else if (tmr != '1) begin
        tmr <= tmr + 1'b1;
      end
    end
  end

  // Registered outputs
  // supply-ok only in run
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      supply_ok_n_oe <= 1'b0;
      switching_en <= 1'b0;
      soft_start_active <= 1'b0;
      fault_latched <= 1'b0;
      seq_state <= ST_DISABLE;
    end else if (clk_en) begin
      supply_ok_n_oe <= (next_state == ST_RUN) && !fault_now;
      switching_en <= next_state == ST_SOFT || next_state == ST_DEGLITCH
                      || next_state == ST_RUN;
      soft_start_active <= next_state == ST_SOFT;
      fault_latched <= next_state == ST_LATCHED;
      seq_state <= next_state;
    end
  end

  // Checks
  // ok implies run
  chk_ok_needs_run: assert property (@(posedge core_clk) disable iff (!rst_n)
    supply_ok_n_oe |-> (seq_state == ST_RUN && switching_en))
    else $error("supply ok driven outside run");
  chk_latch_no_switch: assert property (@(posedge core_clk) disable iff (!rst_n)
    fault_latched |-> !switching_en && !supply_ok_n_oe)
    else $error("switching while latched");
  chk_off_on_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && !filt[IN_ON] && state == ST_RUN |=> !switching_en)
    else $error("switching after turn-on low");
  chk_high_trip: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state == ST_RUN && filt[IN_ON] && !lockout && !filt[IN_ANA_UV]
    && filt[IN_MAIN_HIGH] |=> fault_latched)
    else $error("rail high did not latch");
  chk_no_clear_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state == ST_LATCHED && fault_now && !filt[IN_ANA_UV] |=> state == ST_LATCHED)
    else $error("latch released with fault present");
  chk_lockout_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state == ST_LATCHED && lockout && !filt[IN_ANA_UV] |=> state == ST_LATCHED)
    else $error("lockout released latch");
  chk_analog_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && filt[IN_ANA_UV] |=> !fault_latched && !switching_en)
    else $error("analog low did not clear");
  chk_toggle_time: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state == ST_LATCHED && $past(filt[IN_ON]) && !filt[IN_ANA_UV]
    && !toggle_armed |=> state == ST_LATCHED)
    else $error("latch released without long low");
  chk_deglitch: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_DEGLITCH && next_state == ST_RUN |-> tmr >= CW'(DEGL_CYC - 1))
    else $error("run entered before deglitch");
  cov_reach_run: cover property (@(posedge core_clk) disable iff (!rst_n) state == ST_RUN);
  cov_latch: cover property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_RUN ##1 state == ST_LATCHED);
  cov_release: cover property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_LATCHED ##1 state == ST_SOFT);
  cov_lockout: cover property (@(posedge core_clk) disable iff (!rst_n)
    state == ST_LOCKOUT ##1 state == ST_SOFT);
endmodule : supply_seq
`default_nettype wire

/* dv/host_model.sv */
// Host controller model: drives the turn-on request, reads supply-ok.
// Assumes the bench gives turn-on commands; supply-ok has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic core_clk,
  // Bench command
  input wire logic on_cmd,
  // Device side
  input wire logic supply_ok_n_oe,
  output var logic turn_on_request,
  output logic supply_ok_n
);
  logic cmd_q = 1'b0;
  assign supply_ok_n = supply_ok_n_oe ? 1'b0 : 1'b1; // Released pin floats high
  initial turn_on_request = 1'b0;
  // low time held as commanded
  // Command taken on the rising edge so the bench's falling-edge write never races
  always @(posedge core_clk) begin
    cmd_q <= on_cmd;
  end
  always @(negedge core_clk) begin
    turn_on_request <= cmd_q; // Changes away from the sampling edge
  end
endmodule : host_model
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the supply sequencer with short time counts.
// Assumes the host model drives turn-on; comparators are driven directly.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import supply_seq_pkg::*;
  localparam int TOG = 20;
  localparam int DEG = 50;
  localparam int SFT = 30;
  localparam int TMO = 60;
  localparam int LIMIT_CYC = 40000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic on_cmd = 1'b0;
  logic ul = 1'b0;
  logic al = 1'b1;
  logic oh = 1'b0;
  logic bias = 1'b1;
  logic ce = 1'b1;
  logic [5:0] trip = 6'h00;
  logic ton;
  logic oe;
  logic ok_n;
  logic sw;
  logic ss;
  logic fl;
  seq_state_t st;
  int fail_count = 0;
  int checked = 0;
  always #2.5 core_clk = ~core_clk;
  host_model host_u (.core_clk(core_clk), .on_cmd(on_cmd), .supply_ok_n_oe(oe),
    .turn_on_request(ton), .supply_ok_n(ok_n));
  supply_seq #(.TOGGLE_CYC(TOG), .DEGL_CYC(DEG), .SOFT_CYC(SFT), .TMO_CYC(TMO)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(ce), .turn_on_request(ton),
    .supply_ok_n_oe(oe), .input_low_lockout(ul), .input_analog_low(al),
    .input_high_lockout(oh), .main_rail_low(trip[0]), .aux_rail_low(trip[1]),
    .main_rail_high(trip[2]), .aux_rail_high(trip[3]), .main_rail_bias_ok(bias),
    .main_rail_failsafe(trip[4]), .thermal_trip(trip[5]), .switching_en(sw),
    .soft_start_active(ss), .fault_latched(fl), .seq_state(st));
  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk_bit(string n, logic e, logic g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s expected %b seen %b", n, e, g);
      fail_count++;
    end
  endtask : chk_bit
  task automatic chk_st(string n, seq_state_t e, seq_state_t g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s expected %0h seen %0h", n, e, g);
      fail_count++;
    end
  endtask : chk_st
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  // Bounded wait for a state, then compare
  task automatic run_to(seq_state_t s, int lim);
    int i;
    i = 0;
    while (st !== s && i < lim) begin
      @(negedge core_clk);
      i++;
    end
    chk_st("seq_state", s, st);
  endtask : run_to
  // Expected state a while after a toggle: release needs long low and no fault
  function automatic seq_state_t exp_toggle(int low, logic fault);
    return (low >= TOG && !fault) ? ST_SOFT : ST_LATCHED;
  endfunction : exp_toggle
  // Start-up: no supply-ok before soft-start plus deglitch
  task automatic go_run();
    cyc(SFT + DEG - 10);
    chk_bit("early_ok_oe", 1'b0, oe);
    run_to(ST_RUN, 60);
    cyc(2);
    chk_bit("supply_ok_n", 1'b0, ok_n);
    chk_bit("switching_en", 1'b1, sw);
    chk_bit("soft_start_active", 1'b0, ss);
  endtask : go_run
  task automatic toggle(int low);
    on_cmd = 1'b0;
    cyc(low);
    on_cmd = 1'b1;
  endtask : toggle
  // Hang guard, far beyond the expected run
  initial begin
    repeat (LIMIT_CYC) @(posedge core_clk);
    fail_count++;
    summarize();
  end
  initial begin
    int lo;
    void'($urandom(75));
    cyc(5);
    rst_n = 1'b1;
    al = 1'b0;
    on_cmd = 1'b1;
    go_run();
    on_cmd = 1'b0;
    run_to(ST_DISABLE, 20);
    chk_bit("switching_en", 1'b0, sw);
    on_cmd = 1'b1;
    go_run();
    // Frozen block holds its state while turn-on drops, then acts on it
    ce = 1'b0;
    on_cmd = 1'b0;
    cyc(20);
    chk_st("seq_state", ST_RUN, st);
    ce = 1'b1;
    run_to(ST_DISABLE, 20);
    on_cmd = 1'b1;
    go_run();
    // Short glitch must be filtered out
    trip[2] = 1'b1;
    cyc(2);
    trip = 6'h00;
    cyc(20);
    chk_st("seq_state", ST_RUN, st);
    for (int k = 0; k < 6; k++) begin
      trip[k] = 1'b1;
      run_to(ST_LATCHED, 20);
      cyc(2);
      chk_bit("switching_en", 1'b0, sw);
      chk_bit("supply_ok_n", 1'b1, ok_n);
      toggle(TOG + 5);
      cyc(20);
      chk_st("seq_state", exp_toggle(TOG + 5, 1'b1), st);
      trip = 6'h00;
      cyc(10);
      lo = $urandom_range(4, TOG - 6);
      toggle(lo);
      cyc(20);
      chk_st("seq_state", exp_toggle(lo, 1'b0), st);
      oh = 1'b1;
      cyc(20);
      chk_bit("switching_en", 1'b0, sw);
      oh = 1'b0;
      cyc(20);
      chk_bit("fault_latched", 1'b1, fl);
      lo = TOG + 2 + $urandom_range(0, 30);
      toggle(lo);
      run_to(exp_toggle(lo, 1'b0), 20);
      go_run();
    end
    oh = 1'b1;
    run_to(ST_LOCKOUT, 20);
    chk_bit("switching_en", 1'b0, sw);
    oh = 1'b0;
    run_to(ST_SOFT, 20);
    go_run();
    ul = 1'b1;
    run_to(ST_LOCKOUT, 20);
    // Turn-on settles low before the input recovers
    on_cmd = 1'b0;
    cyc(10);
    ul = 1'b0;
    run_to(ST_DISABLE, 20);
    on_cmd = 1'b1;
    go_run();
    trip[4] = 1'b1;
    run_to(ST_LATCHED, 20);
    trip = 6'h00;
    al = 1'b1;
    run_to(ST_LOCKOUT, 20);
    cyc(2);
    chk_bit("fault_latched", 1'b0, fl);
    al = 1'b0;
    run_to(ST_SOFT, 20);
    go_run();
    on_cmd = 1'b0;
    run_to(ST_DISABLE, 20);
    bias = 1'b0;
    on_cmd = 1'b1;
    run_to(ST_SOFT, 20);
    chk_bit("soft_start_active", 1'b1, ss);
    run_to(ST_LATCHED, TMO + 30);
    bias = 1'b1;
    toggle(TOG + 5);
    run_to(ST_SOFT, 20);
    // Rail low during soft-start is masked, then trips
    trip[0] = 1'b1;
    cyc(10);
    chk_st("seq_state", ST_SOFT, st);
    run_to(ST_LATCHED, SFT + DEG + 40);
    trip = 6'h00;
    summarize();
  end
endmodule : testbench
`default_nettype wire
